// File: inc/bcf_pkg.sv
// Shared constants, types and helpers of the bidirectional queue pair
package bcf_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int DW = 36;
   localparam int PW = 10;
   localparam int AW = 9;
   localparam int OW = 9;
   localparam logic [PW-1:0] DEPTH = 10'h200;
   // Width of the bundle crossing between the two port domains
   localparam int SYNC_W = 2 * PW + 6 + OW * 2 + 1;
   // ----------------------------------------------------------------
   // Offsets and timing
   // ----------------------------------------------------------------
   localparam logic [OW-1:0] OFF_64 = 9'h040;
   localparam logic [OW-1:0] OFF_16 = 9'h010;
   localparam logic [OW-1:0] OFF_8 = 9'h008;
   localparam logic [1:0] SEL_64 = 2'h3;
   localparam logic [1:0] SEL_16 = 2'h2;
   localparam logic [1:0] SEL_PROG = 2'h0;
   localparam logic [1:0] SPACE_WAIT = 2'h2;

   typedef logic [PW-1:0] bcf_ptr_t;
   typedef logic [DW-1:0] bcf_word_t;
   typedef enum logic [2:0] {
      PG_DONE, PG_FULL_AB, PG_EMPTY_AB, PG_FULL_BA, PG_EMPTY_BA
   } bcf_prog_t;

   function automatic bcf_ptr_t bcf_b2g(input bcf_ptr_t b);
      return b ^ (b >> 1);
   endfunction : bcf_b2g

   function automatic bcf_ptr_t bcf_g2b(input bcf_ptr_t g);
      bcf_ptr_t b;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : bcf_g2b

   function automatic logic [OW-1:0] bcf_preset(input logic [1:0] sel);
      case (sel)
         SEL_64: return OFF_64;
         SEL_16: return OFF_16;
         default: return OFF_8;
      endcase
   endfunction : bcf_preset
endpackage : bcf_pkg

// File: src/bcf_bidir_fifo.sv
// Two opposite 512x36 clocked queues with mailboxes between two ports
// Functional notes
// - Queue reset clears pointers and forces flags
// - Space flag rises two write clocks after reset
// - Offset selects captured at queue reset release
// - Nonzero selects load presets 64, 16 or 8
// - First four A writes load offsets, not data
// - Offsets come from port A bits 8..0
// - After programming, B space flag rises
// - Port A drives only selected and reading
// - Port A write stores into A-to-B queue
// - Port A read pops B-to-A queue
// - Port A mailbox write, read frees mailbox
// - Port B mirrors A with inverted direction
// - Port B write stores into B-to-A queue
// - Port B read pops A-to-B queue
// - Port B mailbox write, read frees mailbox
// - Enable low means no transfer that cycle
// - Empty output register loads next word itself
// - Flags synchronised through two stages minimum
// - Flag levels follow word count and offsets
// - Mailbox writes ignored while mailbox holds unread mail
// - First word reaches output after sync delay
// - Queue writes ignored while space flag low
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// One port: writes its own queue, reads the far queue
// ------------------------------------------------------------------
module bcf_side import bcf_pkg::*; #(
   parameter bit IS_A = 1'b1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wq_rst_n,
   input wire logic rq_rst_n,
   input wire logic sel0,
   input wire logic sel1,
   input wire logic select_n,
   input wire logic dir,
   input wire logic enable,
   input wire logic mail_sel,
   input wire bcf_word_t bus_in,
   input wire bcf_ptr_t far_rg_i,
   input wire bcf_ptr_t far_wg_i,
   input wire logic [DW*512-1:0] far_mem,
   input wire bcf_word_t far_mail,
   input wire logic far_mwt_i,
   input wire logic far_mrt_i,
   input wire logic [2*OW:0] far_cfg_i,
   output logic space,
   output logic nfull,
   output logic ready,
   output logic nempty,
   output logic mflag_n,
   output bcf_word_t bus_out,
   output logic bus_oe,
   output bcf_ptr_t wg,
   output bcf_ptr_t rg,
   output logic [DW*512-1:0] mem,
   output bcf_word_t mail,
   output logic mwt,
   output logic mrt,
   output logic [2*OW:0] cfg
);
   typedef struct packed {
      logic [2:0][SYNC_W-1:0] s;
      logic [SYNC_W-1:0] v;
      bcf_prog_t pst;
      logic [OW-1:0] full_ab, empty_ab, full_ba, empty_ba;
      logic [2*OW:0] cfg;
      logic [DW*512-1:0] mem;
      bcf_ptr_t wp, wg, rp, rg;
      logic [1:0] spc;
      logic space, nfull, ready, nempty;
      bcf_word_t outr, mail, bus;
      logic mwt, mrt, mflag_n, oe;
   } bcf_side_t;

   bcf_side_t q, d;
   bcf_ptr_t far_rg, far_wg, used, avail;
   logic wq_ok, rq_ok, fs0, fs1, far_mwt, far_mrt;
   logic [2*OW:0] far_cfg;
   logic [SYNC_W-1:0] agree, eff;
   logic is_write, wr, rd, pop, done, wq_rise, rq_rise;
   logic [OW-1:0] fo, eo;
   logic [1:0] fsel;

   // ----------------------------------------------------------------
   // Crossing: three stages, a bit moves once stages two and three agree
   // ----------------------------------------------------------------
   assign agree = ~(q.s[1] ^ q.s[2]);
   assign eff = (agree & q.s[2]) | (~agree & q.v);
   assign {far_rg, far_wg, wq_ok, rq_ok, fs0, fs1, far_mwt, far_mrt,
           far_cfg} = eff;
   assign fsel = {fs1, fs0};
   assign wq_rise = wq_ok & ~q.v[SYNC_W-2*PW-1];
   assign rq_rise = rq_ok & ~q.v[SYNC_W-2*PW-2];
   // Port B sees the offsets only through the crossing
   assign fo = IS_A ? q.full_ab : far_cfg[2*OW-1:OW];
   assign eo = IS_A ? q.empty_ba : far_cfg[OW-1:0];
   assign done = IS_A ? 1'b1 : far_cfg[2*OW];
   assign is_write = IS_A ? dir : ~dir;
   assign wr = ~select_n & enable & is_write;
   assign rd = ~select_n & enable & ~is_write;

   always_comb begin
      d = q;
      d.s[0] = {far_rg_i, far_wg_i, wq_rst_n, rq_rst_n, sel0, sel1,
                far_mwt_i, far_mrt_i, far_cfg_i};
      d.s[1] = q.s[0];
      d.s[2] = q.s[1];
      d.v = eff;
      // --------------------------------------------------------------
      // Offset selection at reset release
      // --------------------------------------------------------------
      if (IS_A && wq_rise) begin
         if (fsel != SEL_PROG) begin
            d.full_ab = bcf_preset(fsel);
            d.empty_ab = bcf_preset(fsel);
            d.pst = PG_DONE;
         end else begin
            d.pst = PG_FULL_AB;
         end
      end
      if (IS_A && rq_rise && fsel != SEL_PROG) begin
         d.full_ba = bcf_preset(fsel);
         d.empty_ba = bcf_preset(fsel);
      end
      // --------------------------------------------------------------
      // Own queue, write end
      // --------------------------------------------------------------
      if (!wq_ok) begin
         d.wp = '0;
         d.wg = '0;
         d.spc = '0;
      end else begin
         if (q.spc != SPACE_WAIT) begin
            d.spc = q.spc + 2'h1;
         end
         if (wr && !mail_sel && q.space) begin
            if (IS_A && q.pst != PG_DONE) begin
               case (q.pst)
                  PG_FULL_AB: begin
                     d.full_ab = bus_in[OW-1:0];
                     d.pst = PG_EMPTY_AB;
                  end
                  PG_EMPTY_AB: begin
                     d.empty_ab = bus_in[OW-1:0];
                     d.pst = PG_FULL_BA;
                  end
                  PG_FULL_BA: begin
                     d.full_ba = bus_in[OW-1:0];
                     d.pst = PG_EMPTY_BA;
                  end
                  PG_EMPTY_BA: begin
                     d.empty_ba = bus_in[OW-1:0];
                     d.pst = PG_DONE;
                  end
                  default: d.pst = PG_DONE;
               endcase
            end else begin
               d.mem[q.wp[AW-1:0]*DW +: DW] = bus_in;
               d.wp = q.wp + 10'h001;
               d.wg = bcf_b2g(d.wp);
            end
         end
      end
      used = d.wp - bcf_g2b(far_rg);
      // Full and near-full levels, registered once after the crossing
      d.space = wq_ok && q.spc >= SPACE_WAIT - 2'h1 && used != DEPTH
                && done;
      d.nfull = !wq_ok || used < DEPTH - {1'b0, fo};
      // --------------------------------------------------------------
      // Far queue, read end
      // --------------------------------------------------------------
      avail = bcf_g2b(far_wg) - q.rp;
      pop = 1'b0;
      if (!rq_ok) begin
         d.rp = '0;
         d.rg = '0;
         d.ready = 1'b0;
      end else begin
         // Idle output register fetches on its own
         pop = avail != '0 && (!q.ready || (rd && !mail_sel));
         if (q.ready && rd && !mail_sel && avail == '0) begin
            d.ready = 1'b0;
         end
         if (pop) begin
            d.outr = far_mem[q.rp[AW-1:0]*DW +: DW];
            d.rp = q.rp + 10'h001;
            d.rg = bcf_b2g(d.rp);
            d.ready = 1'b1;
         end
      end
      d.nempty = rq_ok && avail - {9'h000, pop} > {1'b0, eo};
      // --------------------------------------------------------------
      // Mailboxes: toggle pairs, so no flag has two clock owners
      // --------------------------------------------------------------
      if (!wq_ok) begin
         d.mwt = 1'b0;
      end else if (wr && mail_sel && q.mflag_n) begin
         d.mail = bus_in;
         d.mwt = ~q.mwt;
      end
      d.mflag_n = !wq_ok || d.mwt == far_mrt;
      if (!rq_ok) begin
         d.mrt = 1'b0;
      end else if (rd && mail_sel && far_mwt != q.mrt) begin
         d.mrt = ~q.mrt;
      end
      // --------------------------------------------------------------
      // Pins, registered so every output leaves a flip-flop
      // --------------------------------------------------------------
      d.bus = mail_sel ? far_mail : d.outr;
      d.oe = ~select_n & ~is_write;
      d.cfg = {q.pst == PG_DONE, q.full_ba, q.empty_ab};
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         q <= '0;
         q.nfull <= 1'b1;
         q.mflag_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign space = q.space;
   assign nfull = q.nfull;
   assign ready = q.ready;
   assign nempty = q.nempty;
   assign mflag_n = q.mflag_n;
   assign bus_out = q.bus;
   assign bus_oe = q.oe;
   assign wg = q.wg;
   assign rg = q.rg;
   assign mem = q.mem;
   assign mail = q.mail;
   assign mwt = q.mwt;
   assign mrt = q.mrt;
   assign cfg = q.cfg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_space_up;
      !q.space ##1 q.space;
   endsequence

   a_reset_write_flags: assert property (@(posedge clk) disable iff (!rstn)
      !q.v[SYNC_W-2*PW-1] |=> !q.space && q.nfull && q.mflag_n)
      else $error("write side flags wrong in queue reset");
   a_reset_read_flags: assert property (@(posedge clk) disable iff (!rstn)
      !q.v[SYNC_W-2*PW-2] |=> !q.ready && !q.nempty && q.rp == '0)
      else $error("read side not cleared in queue reset");
   a_space_after_reset: assert property (@(posedge clk) disable iff (!rstn)
      wq_rise && done && d.v == eff |=> s_space_up)
      else $error("space flag not raised on second edge");
   a_full_write_ignored: assert property (@(posedge clk)
      disable iff (!rstn)
      wr && !mail_sel && !q.space |=> $stable(q.wp))
      else $error("write taken while space flag low");
   a_prog_not_stored: assert property (@(posedge clk) disable iff (!rstn)
      q.pst != PG_DONE && wr && !mail_sel |=> $stable(q.wp))
      else $error("offset write stored into queue");
   a_read_advance: assert property (@(posedge clk) disable iff (!rstn)
      rq_ok && q.ready && rd && !mail_sel && avail != '0
      |=> q.rp == $past(q.rp) + 10'h001 && q.ready)
      else $error("selected read did not advance");
   a_auto_load: assert property (@(posedge clk) disable iff (!rstn)
      rq_ok && !q.ready && avail != '0 |=> q.ready)
      else $error("output register not loaded on its own");
   a_mail_blocked: assert property (@(posedge clk) disable iff (!rstn)
      wr && mail_sel && !q.mflag_n |=> $stable(q.mail))
      else $error("mailbox overwritten before read");
   a_mail_flag_low: assert property (@(posedge clk) disable iff (!rstn)
      wq_ok && wr && mail_sel && q.mflag_n |=> !q.mflag_n)
      else $error("mailbox write did not lower flag");
   a_idle_enable: assert property (@(posedge clk) disable iff (!rstn)
      !enable && q.ready && wq_ok && rq_ok
      |=> $stable(q.rp) && $stable(q.wp) && $stable(q.mail))
      else $error("transfer while enable low");
   a_bus_enable: assert property (@(posedge clk) disable iff (!rstn)
      select_n || is_write |=> !q.oe ##1 1'b1)
      else $error("bus driven while deselected or writing");
   a_preset_load: assert property (@(posedge clk) disable iff (!rstn)
      IS_A && wq_rise && fsel == SEL_64 |=> q.full_ab == OFF_64)
      else $error("preset offset not loaded");
endmodule : bcf_side

// ------------------------------------------------------------------
// Top: port A on clock, port B on its own clock
// ------------------------------------------------------------------
module bcf_bidir_fifo import bcf_pkg::*; (
   input wire logic clock,
   input wire logic rstn,
   input wire logic port_b_clock,
   input wire logic queue_ab_reset_n,
   input wire logic queue_ba_reset_n,
   input wire logic offset_sel0,
   input wire logic offset_sel1,
   input wire logic port_a_select_n,
   input wire logic port_a_write_nread,
   input wire logic port_a_enable,
   input wire logic port_a_mail_sel,
   input wire bcf_word_t port_a_bus_in,
   output bcf_word_t port_a_bus_out,
   output logic port_a_bus_oe,
   input wire logic port_b_select_n,
   input wire logic port_b_nwrite_read,
   input wire logic port_b_enable,
   input wire logic port_b_mail_sel,
   input wire bcf_word_t port_b_bus_in,
   output bcf_word_t port_b_bus_out,
   output logic port_b_bus_oe,
   output logic a_space_flag,
   output logic a_near_full_n,
   output logic a_data_ready,
   output logic a_near_empty_n,
   output logic b_space_flag,
   output logic b_near_full_n,
   output logic b_data_ready,
   output logic b_near_empty_n,
   output logic mail_ab_flag_n,
   output logic mail_ba_flag_n
);
   bcf_ptr_t a_wg, a_rg, b_wg, b_rg;
   logic [DW*512-1:0] a_mem, b_mem;
   bcf_word_t a_mail, b_mail;
   logic a_mwt, a_mrt, b_mwt, b_mrt;
   logic [2*OW:0] a_cfg;

   bcf_side #(.IS_A(1'b1)) u_port_a (
      .clk(clock), .rstn(rstn), .wq_rst_n(queue_ab_reset_n),
      .rq_rst_n(queue_ba_reset_n), .sel0(offset_sel0),
      .sel1(offset_sel1), .select_n(port_a_select_n),
      .dir(port_a_write_nread), .enable(port_a_enable),
      .mail_sel(port_a_mail_sel), .bus_in(port_a_bus_in),
      .far_rg_i(b_rg), .far_wg_i(b_wg), .far_mem(b_mem),
      .far_mail(b_mail), .far_mwt_i(b_mwt), .far_mrt_i(b_mrt),
      .far_cfg_i('0), .space(a_space_flag), .nfull(a_near_full_n),
      .ready(a_data_ready), .nempty(a_near_empty_n),
      .mflag_n(mail_ab_flag_n), .bus_out(port_a_bus_out),
      .bus_oe(port_a_bus_oe), .wg(a_wg), .rg(a_rg), .mem(a_mem),
      .mail(a_mail), .mwt(a_mwt), .mrt(a_mrt), .cfg(a_cfg)
   );

   bcf_side #(.IS_A(1'b0)) u_port_b (
      .clk(port_b_clock), .rstn(rstn), .wq_rst_n(queue_ba_reset_n),
      .rq_rst_n(queue_ab_reset_n), .sel0(offset_sel0),
      .sel1(offset_sel1), .select_n(port_b_select_n),
      .dir(port_b_nwrite_read), .enable(port_b_enable),
      .mail_sel(port_b_mail_sel), .bus_in(port_b_bus_in),
      .far_rg_i(a_rg), .far_wg_i(a_wg), .far_mem(a_mem),
      .far_mail(a_mail), .far_mwt_i(a_mwt), .far_mrt_i(a_mrt),
      .far_cfg_i(a_cfg), .space(b_space_flag), .nfull(b_near_full_n),
      .ready(b_data_ready), .nempty(b_near_empty_n),
      .mflag_n(mail_ba_flag_n), .bus_out(port_b_bus_out),
      .bus_oe(port_b_bus_oe), .wg(b_wg), .rg(b_rg), .mem(b_mem),
      .mail(b_mail), .mwt(b_mwt), .mrt(b_mrt), .cfg()
   );
endmodule : bcf_bidir_fifo

`default_nettype wire

// File: tb/bcf_port_b_model.sv
// Port B bus-master model: queue and mailbox transfers on port B clock
`timescale 1ns/1ps
`default_nettype none
module bcf_port_b_model import bcf_pkg::*; (
   input wire logic port_b_clock,
   input wire logic b_space_flag,
   input wire logic b_data_ready,
   input wire bcf_word_t port_b_bus_out,
   output logic port_b_select_n,
   output logic port_b_nwrite_read,
   output logic port_b_enable,
   output logic port_b_mail_sel,
   output bcf_word_t port_b_bus_in
);
   // ---------------------------------------------------------------
   // Transfers
   // ---------------------------------------------------------------
   bit slow = 1'b0;
   bcf_word_t got_d;
   event got_e;
   initial begin
      port_b_select_n = 1'b1;
      port_b_nwrite_read = 1'b0;
      port_b_enable = 1'b0;
      port_b_mail_sel = 1'b0;
      port_b_bus_in = '0;
   end
   // op[1] read, op[0] mailbox; mode is set one edge early so the
   // output register has switched before the first enabled edge
   task automatic b_op(input logic [1:0] op, input bcf_word_t d,
         input int n, input int limit, output int c);
      logic take;
      c = 0;
      @(posedge port_b_clock) #1;
      port_b_select_n = 1'b0;
      port_b_nwrite_read = op[1];
      port_b_mail_sel = op[0];
      @(posedge port_b_clock) #1;
      for (int i = 0; i < limit && c < n; i++) begin
         port_b_enable = slow ? 1'($urandom % 2) : 1'b1;
         port_b_bus_in = op[1] ? ~port_b_bus_in : d + bcf_word_t'(c);
         @(negedge port_b_clock);
         take = port_b_enable && (op[0] ||
            (op[1] ? b_data_ready : b_space_flag));
         got_d = port_b_bus_out;
         @(posedge port_b_clock) #1;
         if (take) c++;
         if (take && op[1]) -> got_e;
      end
      // Released bus shows the inverse, never a stale word
      port_b_select_n = 1'b1;
      port_b_enable = 1'b0;
      port_b_bus_in = ~port_b_bus_in;
   endtask : b_op
endmodule : bcf_port_b_model
`default_nettype wire

// File: tb/bcf_bidir_fifo_tb.sv
// Self-checking bench of the bidirectional queue pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end
module bcf_bidir_fifo_tb import bcf_pkg::*; ;
   // ---------------------------------------------------------------
   // Harness
   // ---------------------------------------------------------------
   logic clock = 1'b0;
   logic port_b_clock = 1'b0;
   logic rstn = 1'b0;
   logic queue_ab_reset_n = 1'b0;
   logic queue_ba_reset_n = 1'b0;
   logic offset_sel0 = 1'b0;
   logic offset_sel1 = 1'b0;
   logic port_a_select_n = 1'b1;
   logic port_a_write_nread = 1'b0;
   logic port_a_enable = 1'b0;
   logic port_a_mail_sel = 1'b0;
   bcf_word_t port_a_bus_in = '0;
   bcf_word_t port_a_bus_out, port_b_bus_out, port_b_bus_in;
   logic port_a_bus_oe, port_b_bus_oe, port_b_select_n, port_b_enable;
   logic port_b_nwrite_read, port_b_mail_sel;
   logic a_space_flag, a_near_full_n, a_data_ready, a_near_empty_n;
   logic b_space_flag, b_near_full_n, b_data_ready, b_near_empty_n;
   logic mail_ab_flag_n, mail_ba_flag_n;
   int fail_count = 0;
   int cmp_count = 0;
   bit prog = 1'b0;
   bit a_slow = 1'b0;
   bcf_word_t exp_ab[$], exp_ba[$], a_got_d, e_ab, e_ba, d;
   logic [8:0] x;
   int cnt;
   event a_got_e;

   bcf_bidir_fifo u_bcf_bidir_fifo (.clock, .rstn, .port_b_clock,
      .queue_ab_reset_n, .queue_ba_reset_n, .offset_sel0, .offset_sel1,
      .port_a_select_n, .port_a_write_nread, .port_a_enable,
      .port_a_mail_sel, .port_a_bus_in, .port_a_bus_out, .port_a_bus_oe,
      .port_b_select_n, .port_b_nwrite_read, .port_b_enable,
      .port_b_mail_sel, .port_b_bus_in, .port_b_bus_out, .port_b_bus_oe,
      .a_space_flag, .a_near_full_n, .a_data_ready, .a_near_empty_n,
      .b_space_flag, .b_near_full_n, .b_data_ready, .b_near_empty_n,
      .mail_ab_flag_n, .mail_ba_flag_n);
   bcf_port_b_model u_bcf_port_b_model (.port_b_clock, .b_space_flag,
      .b_data_ready, .port_b_bus_out, .port_b_select_n,
      .port_b_nwrite_read, .port_b_enable, .port_b_mail_sel,
      .port_b_bus_in);

   initial forever #12.5 clock = ~clock;
   initial begin
      #7;
      forever #62.5 port_b_clock = ~port_b_clock;
   end
   initial begin
      #2500000;
      fail_count++;
      conclude();
   end
   // Each word read at a port is matched against the oldest note
   always @(u_bcf_port_b_model.got_e) begin
      e_ab = exp_ab.size() ? exp_ab.pop_front() : ~u_bcf_port_b_model.got_d;
      `CHK(u_bcf_port_b_model.got_d, e_ab);
      `CHK(port_b_bus_oe, 1'b1);
   end
   always @(a_got_e) begin
      e_ba = exp_ba.size() ? exp_ba.pop_front() : ~a_got_d;
      `CHK(a_got_d, e_ba);
      `CHK(port_a_bus_oe, 1'b1);
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   task automatic settle();
      repeat (12) @(posedge port_b_clock);
      @(negedge port_b_clock);
   endtask : settle

   task automatic a_op(input logic [1:0] op, input bcf_word_t dw,
         input int n, input int limit, output int c);
      logic take;
      c = 0;
      @(posedge clock) #1;
      port_a_select_n = 1'b0;
      port_a_write_nread = !op[1];
      port_a_mail_sel = op[0];
      @(posedge clock) #1;
      for (int i = 0; i < limit && c < n; i++) begin
         port_a_enable = a_slow ? 1'($urandom % 2) : 1'b1;
         port_a_bus_in = op[1] ? ~port_a_bus_in : dw + bcf_word_t'(c);
         @(negedge clock);
         take = port_a_enable && (op[0] ||
            (op[1] ? a_data_ready : a_space_flag));
         a_got_d = port_a_bus_out;
         if (take && op == 2'h0 && !prog) exp_ab.push_back(port_a_bus_in);
         @(posedge clock) #1;
         if (take) c++;
         if (take && op[1]) -> a_got_e;
      end
      port_a_select_n = 1'b1;
      port_a_enable = 1'b0;
      port_a_bus_in = ~port_a_bus_in;
   endtask : a_op

   // Both queues held low for five port B edges, then released
   task automatic reset_all(input logic [1:0] fs);
      @(posedge clock) #1;
      queue_ab_reset_n = 1'b0;
      queue_ba_reset_n = 1'b0;
      {offset_sel1, offset_sel0} = fs;
      repeat (5) @(posedge port_b_clock);
      #1;
      `CHK({a_space_flag, a_data_ready, a_near_empty_n, a_near_full_n,
         b_space_flag, b_data_ready, b_near_empty_n, b_near_full_n,
         mail_ab_flag_n, mail_ba_flag_n}, 10'h047);
      queue_ab_reset_n = 1'b1;
      queue_ba_reset_n = 1'b1;
      for (int i = 0; i < 20 && a_space_flag !== 1'b1; i++)
         @(negedge clock);
      `CHK(a_space_flag, 1'b1);
   endtask : reset_all

   // Near-empty boundary: the output register word is not counted
   task automatic ae_check(input logic [8:0] xo);
      int c;
      d = bcf_word_t'($urandom);
      a_op(2'h0, d, xo + 1, xo + 40, c);
      settle();
      `CHK(b_near_empty_n, 1'b0);
      a_op(2'h0, d + 36'h1, 1, 20, c);
      settle();
      `CHK(b_near_empty_n, 1'b1);
      u_bcf_port_b_model.b_op(2'h2, d, xo + 2, 8 * xo + 64, c);
      `CHK(c, xo + 2);
      settle();
      `CHK({b_data_ready, b_near_empty_n}, 2'h0);
   endtask : ae_check

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      cnt = $urandom(98);
      repeat (4) @(posedge port_b_clock);
      #1 rstn = 1'b1;
      for (int k = 1; k < 4; k++) begin
         reset_all(2'(k));
         for (int i = 0; i < 10 && b_space_flag !== 1'b1; i++)
            @(negedge port_b_clock);
         `CHK(b_space_flag, 1'b1);
         x = (k == 3) ? 9'h040 : (k == 2) ? 9'h010 : 9'h008;
         ae_check(x);
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge clock) #1;
         {port_a_select_n, port_a_write_nread} = 2'(k);
         repeat (2) @(negedge clock);
         `CHK(port_a_bus_oe, k == 0);
      end
      port_a_select_n = 1'b1;
      d = bcf_word_t'($urandom);
      a_op(2'h0, d, 514, 600, cnt);
      `CHK(cnt, 513);
      `CHK({a_space_flag, a_near_full_n}, 2'h0);
      u_bcf_port_b_model.slow = 1'b1;
      u_bcf_port_b_model.b_op(2'h2, d, 513, 3000, cnt);
      `CHK(cnt, 513);
      prog = 1'b1;
      reset_all(2'h0);
      settle();
      `CHK(b_space_flag, 1'b0);
      x = 9'(1 + $urandom % 20);
      for (int k = 0; k < 4; k++) begin
         d = bcf_word_t'({$urandom, (k == 1) ? x : 9'h1fc});
         a_op(2'h0, d, 1, 20, cnt);
         `CHK(cnt, 1);
      end
      prog = 1'b0;
      for (int i = 0; i < 20 && b_space_flag !== 1'b1; i++)
         @(negedge port_b_clock);
      `CHK(b_space_flag, 1'b1);
      ae_check(x);
      d = bcf_word_t'($urandom);
      u_bcf_port_b_model.b_op(2'h0, d, 6, 100, cnt);
      `CHK(cnt, 6);
      for (int k = 0; k < 6; k++) exp_ba.push_back(d + bcf_word_t'(k));
      a_slow = 1'b1;
      a_op(2'h2, d, 6, 200, cnt);
      `CHK(cnt, 6);
      a_slow = 1'b0;
      u_bcf_port_b_model.slow = 1'b0;
      a_op(2'h1, d, 1, 4, cnt);
      @(negedge clock);
      `CHK(mail_ab_flag_n, 1'b0);
      a_op(2'h1, ~d, 1, 4, cnt);
      exp_ab.push_back(d);
      // Mail toggle needs the crossing before port B may free the mailbox
      settle();
      u_bcf_port_b_model.b_op(2'h3, d, 1, 4, cnt);
      for (int i = 0; i < 40 && mail_ab_flag_n !== 1'b1; i++)
         @(negedge clock);
      `CHK(mail_ab_flag_n, 1'b1);
      u_bcf_port_b_model.b_op(2'h1, ~d, 1, 4, cnt);
      settle();
      `CHK(mail_ba_flag_n, 1'b0);
      exp_ba.push_back(~d);
      a_op(2'h3, d, 1, 4, cnt);
      for (int i = 0; i < 10 && mail_ba_flag_n !== 1'b1; i++)
         @(negedge port_b_clock);
      `CHK(mail_ba_flag_n, 1'b1);
      conclude();
   end
endmodule : bcf_bidir_fifo_tb
`default_nettype wire
